// ---- slc_regs.svh ----
// Register map, field positions, reset values and limits of the serial link control bank.
// Included by slc_pkg; holds definitions only.
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

// Bus widths.
`define SLC_AW 12
`define SLC_DW 8
`define SLC_CW 16

// Device bank offsets.
`define SLC_A_ENABLE 12'h200
`define SLC_A_FORMAT 12'h201
`define SLC_A_KM1    12'h202
`define SLC_A_SSYNC  12'h203
`define SLC_A_CTRL   12'h204

// Device reset values.
`define SLC_R_ENABLE 8'h01
`define SLC_R_FORMAT 8'h02
`define SLC_R_KM1    8'h1f
`define SLC_R_SSYNC  8'h01
`define SLC_R_CTRL   8'h03

// Field positions.
`define SLC_B_ENABLE  0
`define SLC_B_SSYNC   0
`define SLC_B_SCR     0
`define SLC_B_SFORMAT 1
`define SLC_B_SEL_LO  2
`define SLC_B_SEL_HI  3
`define SLC_B_ALT     4

// Sync source codes.
`define SLC_SEL_PIN 2'h0
`define SLC_SEL_TS  2'h1
`define SLC_SEL_SW  2'h2

// Formats at or above this code use 64b/66b framing.
`define SLC_FMT_66B_FIRST 8'h10
// Smallest legal frames-per-multiframe minus one in 8b/10b formats.
`define SLC_KM1_MIN 8'h03

// Controller register offsets.
`define SLC_H_SEL   4'h0
`define SLC_H_DATA  4'h1
`define SLC_H_GO    4'h2
`define SLC_H_CAL   4'h3
`define SLC_H_STAT  4'h4
`define SLC_H_RDATA 4'h5

// Controller field positions.
`define SLC_GO_WR   0
`define SLC_GO_RD   1
`define SLC_ST_BUSY 0
`define SLC_ST_REF  1
`define SLC_ST_RDV  2

`endif

// ---- slc_pkg.sv ----
// Types shared by both ends of the serial link control bank.
// Assumes slc_regs.svh is on the include path.
package slc_pkg;
  `include "slc_regs.svh"

  typedef enum logic {SLC_H_IDLE, SLC_H_RDWAIT} slc_hstate_t;

  typedef struct packed {
    logic [`SLC_DW-1:0] en;
    logic [`SLC_DW-1:0] fmt;
    logic [`SLC_DW-1:0] km1;
    logic [`SLC_DW-1:0] ssync;
    logic [`SLC_DW-1:0] ctrl;
    logic [`SLC_DW-1:0] rdata;
    logic [`SLC_CW-1:0] cnt;
    logic               en_d;
    logic               start;
    logic               link_rst_n;
    logic               serdes_pd;
    logic               clk_en;
    logic               se1;
    logic               se2;
    logic               ts1;
    logic               ts2;
    logic               sr1;
    logic               sr2;
    logic               sr3;
    logic               sync_req;
    logic               boundary;
  } slc_dev_state_t;

  typedef struct packed {
    slc_hstate_t        state;
    logic [2:0]         sel;
    logic [`SLC_DW-1:0] data;
    logic               cal;
    logic               sh_en;
    logic [`SLC_DW-1:0] sh_fmt;
    logic               refused;
    logic               rdv;
    logic [`SLC_DW-1:0] bank_rd;
    logic [`SLC_AW-1:0] addr;
    logic [`SLC_DW-1:0] wdata;
    logic               wr;
    logic               rd;
    logic [`SLC_DW-1:0] urd;
  } slc_host_state_t;
endpackage : slc_pkg

// ---- slc_link_if.sv ----
// Register access path between the controller and the link control bank.
// One clock shared by both ends; strobes are one cycle, read data follows a read by one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
interface slc_link_if;
  logic [`SLC_AW-1:0] addr;
  logic [`SLC_DW-1:0] wdata;
  logic               wr;
  logic               rd;
  logic [`SLC_DW-1:0] rdata;

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : slc_link_if
`default_nettype wire

// ---- slc_host_end.sv ----
// Controller end: takes orders from software and drives the link control bank.
// Assumes it is the only master of the bank, so its shadow of the enable bit is exact.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module slc_host_end (
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rstn,
  // Software port
  input  wire logic [3:0]           i_addr,
  input  wire logic [`SLC_DW-1:0]   i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [`SLC_DW-1:0]   o_rdata,
  // Calibration control
  output logic                      o_cal_en,
  // Bank access
  slc_link_if.host                  bus
);
  import slc_pkg::*;

  slc_host_state_t r;
  slc_host_state_t n;
  logic            ref_ev;

  // Decides whether a bank write may go out given the present link state.
  function automatic logic wr_ok(input logic [2:0] idx, input logic [`SLC_DW-1:0] d,
                                 input logic en, input logic cal,
                                 input logic [`SLC_DW-1:0] fmt);
    case (idx)
      3'h0:    wr_ok = !(d[`SLC_B_ENABLE] && !cal);
      3'h1:    wr_ok = !en && !cal;
      3'h2:    wr_ok = !en && (fmt >= `SLC_FMT_66B_FIRST ||
                               d >= `SLC_KM1_MIN);
      // A sync request must be possible while the link runs.
      3'h3:    wr_ok = 1'b1;
      3'h4:    wr_ok = !en;
      default: wr_ok = 1'b0;
    endcase
  endfunction : wr_ok

  always_comb begin
    n      = r;
    ref_ev = 1'b0;
    n.wr   = 1'b0;
    n.rd   = 1'b0;
    n.urd  = 8'h00;
    unique case (r.state)
      SLC_H_IDLE: begin
      end
      SLC_H_RDWAIT: begin
        // The bank answers one cycle after its strobe, so wait while the strobe is out.
        if (!r.rd) begin
          n.bank_rd = bus.rdata;
          n.rdv     = 1'b1;
          n.state   = SLC_H_IDLE;
        end
      end
    endcase
    if (i_wr) begin
      case (i_addr)
        `SLC_H_SEL:  n.sel = i_wdata[2:0];
        `SLC_H_DATA: n.data = i_wdata;
        `SLC_H_GO: begin
          if (i_wdata[`SLC_GO_WR]) begin
            if (wr_ok(r.sel, r.data, r.sh_en, r.cal, r.sh_fmt)) begin
              n.wr    = 1'b1;
              n.addr  = `SLC_A_ENABLE + {9'h000, r.sel};
              n.wdata = r.data;
              if (r.sel == 3'h0) begin
                n.sh_en = r.data[`SLC_B_ENABLE];
              end
              if (r.sel == 3'h1) begin
                n.sh_fmt = r.data;
              end
            end else begin
              ref_ev = 1'b1;
            end
          end else if (i_wdata[`SLC_GO_RD]) begin
            n.rd    = 1'b1;
            n.addr  = `SLC_A_ENABLE + {9'h000, r.sel};
            n.rdv   = 1'b0;
            n.state = SLC_H_RDWAIT;
          end
        end
        `SLC_H_CAL: begin
          if (!i_wdata[0] && r.sh_en && r.cal) begin
            ref_ev = 1'b1;
          end else begin
            n.cal = i_wdata[0];
          end
        end
        `SLC_H_STAT: begin
          if (i_wdata[`SLC_ST_REF]) begin
            n.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A refusal in the same cycle as its clear is kept.
    if (ref_ev) begin
      n.refused = 1'b1;
    end
    if (i_rd) begin
      case (i_addr)
        `SLC_H_SEL:   n.urd = {5'h00, r.sel};
        `SLC_H_DATA:  n.urd = r.data;
        `SLC_H_CAL:   n.urd = {7'h00, r.cal};
        `SLC_H_STAT:  n.urd = {5'h00, r.rdv, r.refused, r.state == SLC_H_RDWAIT};
        `SLC_H_RDATA: n.urd = r.bank_rd;
        default:      n.urd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '{state: SLC_H_IDLE, sel: 3'h0, data: 8'h00, cal: 1'b0,
             sh_en: 1'(`SLC_R_ENABLE), sh_fmt: `SLC_R_FORMAT,
             refused: 1'b0, rdv: 1'b0, bank_rd: 8'h00, addr: 12'h000,
             wdata: 8'h00, wr: 1'b0, rd: 1'b0, urd: 8'h00};
    end else begin
      r <= n;
    end
  end

  assign o_rdata   = r.urd;
  assign o_cal_en  = r.cal;
  assign bus.addr  = r.addr;
  assign bus.wdata = r.wdata;
  assign bus.wr    = r.wr;
  assign bus.rd    = r.rd;
endmodule : slc_host_end
`default_nettype wire

// ---- slc_dev_end.sv ----
// Device end: the serial link control bank and the link-side logic that it steers.
// Assumes a single master on the bank and a frame tick from the framing logic on this clock.
//
// Contract
// - Enable low: link reset, serializers down, clocks gated.
// - Enable low holds multiframe counter in reset.
// - Clear enable before changing other link configuration.
// - Set calibration enable before setting link enable.
// - Clear link enable before clearing calibration enable.
// - Enable is bit 0, resets to 1.
// - Eight-bit format field, resets to 0x02.
// - Change format only with enable and calibration low.
// - Permission lock limits which formats are accepted.
// - Multiframe length field holds frames minus one.
// - Multiframe length resets to 31, thirty-two frames.
// - Software programs only frame counts legal for format.
// - 64b/66b formats use 256 times E over F.
// - Writing 0 to soft sync bit requests sync.
// - Soft sync works with any source, combined with pin.
// - Stuck-low pin keeps request unless source is 2.
// - Source 0 sync pin, 1 timestamp, 2 software.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module slc_dev_end (
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rstn,
  // Bank access from the controller
  slc_link_if.dev                   bus,
  // Pins from the receiver side, asynchronous
  input  wire logic                 i_sync_pin_n,
  input  wire logic                 i_timestamp_pin_n,
  input  wire logic                 i_sysref,
  // Framing inputs on this clock
  input  wire logic                 i_frame_tick,
  input  wire logic [`SLC_DW-1:0]   i_format_limit,
  input  wire logic [`SLC_DW-1:0]   i_frame_octets_f,
  input  wire logic [`SLC_DW-1:0]   i_multiblocks_e,
  // Link controls
  output logic                      o_link_rst_n,
  output logic                      o_serdes_pd,
  output logic                      o_link_clk_en,
  output logic                      o_link_start,
  output logic [`SLC_DW-1:0]        o_link_format,
  output logic                      o_scramble_en,
  output logic                      o_twos_comp,
  output logic                      o_alt_lanes,
  // Synchronisation and multiframe timing
  output logic                      o_sync_request,
  output logic                      o_mf_boundary,
  output logic [`SLC_CW-1:0]        o_mf_count
);
  import slc_pkg::*;

  slc_dev_state_t     r;
  slc_dev_state_t     n;
  logic               link_on;
  logic               sysref_edge;
  logic               pin_req;
  logic [1:0]         sync_sel;
  logic [`SLC_CW-1:0] last_frame;

  // Index of the last frame in a multiframe.
  function automatic logic [`SLC_CW-1:0] mf_last(input logic [`SLC_DW-1:0] fmt,
                                                 input logic [`SLC_DW-1:0] km1,
                                                 input logic [`SLC_DW-1:0] e,
                                                 input logic [`SLC_DW-1:0] f);
    logic [`SLC_CW-1:0] k;
    k = 16'h0000;
    if (fmt >= `SLC_FMT_66B_FIRST && f != 8'h00) begin
      // The length field plays no part here.
      k = {e, 8'h00} / {8'h00, f};
      mf_last = (k == 16'h0000) ? 16'h0000 : k - 16'h0001;
    end else begin
      // The field already holds frames minus one.
      mf_last = {8'h00, km1};
    end
  endfunction : mf_last

  always_comb begin
    n           = r;
    link_on     = r.en[`SLC_B_ENABLE];
    sync_sel    = r.ctrl[`SLC_B_SEL_HI:`SLC_B_SEL_LO];
    sysref_edge = r.sr2 && !r.sr3;
    last_frame  = mf_last(r.fmt, r.km1, i_multiblocks_e, i_frame_octets_f);
    pin_req     = 1'b0;

    // Pins pass two flops before anything looks at them.
    n.se1 = i_sync_pin_n;
    n.se2 = r.se1;
    n.ts1 = i_timestamp_pin_n;
    n.ts2 = r.ts1;
    n.sr1 = i_sysref;
    n.sr2 = r.sr1;
    n.sr3 = r.sr2;

    // Whole bytes are stored, reserved bits included, and only the
    // documented bits are ever decoded.
    if (bus.wr) begin
      case (bus.addr)
        `SLC_A_ENABLE: n.en = bus.wdata;
        `SLC_A_FORMAT: begin
          // A format above the permission limit leaves the old one in place.
          if (bus.wdata <= i_format_limit) begin
            n.fmt = bus.wdata;
          end
        end
        `SLC_A_KM1:    n.km1 = bus.wdata;
        `SLC_A_SSYNC:  n.ssync = bus.wdata;
        `SLC_A_CTRL:   n.ctrl = bus.wdata;
        default: begin
        end
      endcase
    end

    // Read data stand in the cycle after the strobe only.
    n.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `SLC_A_ENABLE: n.rdata = r.en;
        `SLC_A_FORMAT: n.rdata = r.fmt;
        `SLC_A_KM1:    n.rdata = r.km1;
        `SLC_A_SSYNC:  n.rdata = r.ssync;
        `SLC_A_CTRL:   n.rdata = r.ctrl;
        default:       n.rdata = 8'h00;
      endcase
    end

    // Link power, reset and clock gating follow the enable bit.
    n.link_rst_n = link_on;
    n.serdes_pd  = !link_on;
    n.clk_en     = link_on;

    // The start pulse fires once as the link leaves reset, so startup
    // always begins from the initial state with the settings now held.
    n.en_d  = link_on;
    n.start = link_on && !r.en_d;

    // Multiframe counter; SYSREF cannot align it while the link is off.
    n.boundary = 1'b0;
    if (!link_on) begin
      n.cnt = 16'h0000;
    end else if (sysref_edge) begin
      n.cnt = 16'h0000;
    end else if (i_frame_tick) begin
      if (r.cnt >= last_frame) begin
        n.cnt      = 16'h0000;
        n.boundary = 1'b1;
      end else begin
        n.cnt = r.cnt + 16'h0001;
      end
    end

    // Source 3 is not defined; it is treated like the software-only choice.
    unique case (sync_sel)
      `SLC_SEL_PIN: pin_req = !r.se2;
      `SLC_SEL_TS:  pin_req = !r.ts2;
      `SLC_SEL_SW:  pin_req = 1'b0;
      default:      pin_req = 1'b0;
    endcase
    // A low pin cannot be overridden by the software bit.
    n.sync_req = !r.ssync[`SLC_B_SSYNC] || pin_req;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '{en: `SLC_R_ENABLE, fmt: `SLC_R_FORMAT, km1: `SLC_R_KM1,
             ssync: `SLC_R_SSYNC, ctrl: `SLC_R_CTRL, rdata: 8'h00,
             cnt: 16'h0000, en_d: 1'b0, start: 1'b0, link_rst_n: 1'b0,
             serdes_pd: 1'b1, clk_en: 1'b0, se1: 1'b1, se2: 1'b1,
             ts1: 1'b1, ts2: 1'b1, sr1: 1'b0, sr2: 1'b0, sr3: 1'b0,
             sync_req: 1'b0, boundary: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign bus.rdata      = r.rdata;
  assign o_link_rst_n   = r.link_rst_n;
  assign o_serdes_pd    = r.serdes_pd;
  assign o_link_clk_en  = r.clk_en;
  assign o_link_start   = r.start;
  assign o_link_format  = r.fmt;
  assign o_scramble_en  = r.ctrl[`SLC_B_SCR];
  assign o_twos_comp    = r.ctrl[`SLC_B_SFORMAT];
  assign o_alt_lanes    = r.ctrl[`SLC_B_ALT];
  assign o_sync_request = r.sync_req;
  assign o_mf_boundary  = r.boundary;
  assign o_mf_count     = r.cnt;
endmodule : slc_dev_end
`default_nettype wire

// ---- slc_link_chk.sv ----
// Checker for the register access path between the controller and the link control bank.
// Assumes both ends share i_sys_clk; it keeps its own copy of bytes written over the path.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module slc_link_chk (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  // Access path
  input  wire logic [`SLC_AW-1:0] addr,
  input  wire logic [`SLC_DW-1:0] wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  input  wire logic [`SLC_DW-1:0] rdata
);
  logic [`SLC_DW-1:0] m_en;
  logic [`SLC_DW-1:0] m_km1;
  logic [`SLC_DW-1:0] m_ssync;
  logic [`SLC_DW-1:0] m_ctrl;

  // The format byte is not mirrored, because the device may refuse it silently.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      m_en    <= `SLC_R_ENABLE;
      m_km1   <= `SLC_R_KM1;
      m_ssync <= `SLC_R_SSYNC;
      m_ctrl  <= `SLC_R_CTRL;
    end else if (wr) begin
      if (addr == `SLC_A_ENABLE) m_en <= wdata;
      if (addr == `SLC_A_KM1) m_km1 <= wdata;
      if (addr == `SLC_A_SSYNC) m_ssync <= wdata;
      if (addr == `SLC_A_CTRL) m_ctrl <= wdata;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  chk_no_dual_strobe: assert property (!(wr && rd))
    else $error("write and read strobes high together");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data not zero outside a read answer");
  chk_enable_readback: assert property (rd && addr == `SLC_A_ENABLE |=> rdata == m_en)
    else $error("enable byte read back wrong");
  chk_km1_readback: assert property (rd && addr == `SLC_A_KM1 |=> rdata == m_km1)
    else $error("multiframe length read back wrong");
  chk_ssync_readback: assert property (rd && addr == `SLC_A_SSYNC |=> rdata == m_ssync)
    else $error("soft sync byte read back wrong");
  chk_ctrl_readback: assert property (rd && addr == `SLC_A_CTRL |=> rdata == m_ctrl)
    else $error("control byte read back wrong");
  chk_cfg_when_off: assert property (wr && (addr == `SLC_A_FORMAT || addr == `SLC_A_KM1 ||
                                     addr == `SLC_A_CTRL) |-> !m_en[0])
    else $error("configuration written while link enabled");
  chk_addr_in_bank: assert property ((wr || rd) |-> addr >= `SLC_A_ENABLE && addr <= `SLC_A_CTRL)
    else $error("access outside the bank");
endmodule : slc_link_chk
`default_nettype wire

// ---- tb_serial_link_control_regs.sv ----
// Testbench joining the controller end and the device end of the link control bank.
// Assumes the package and slc_regs.svh are compiled first; software port drives the bank, pins and frame tick are driven directly.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module tb_serial_link_control_regs;
  import slc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_cal_en;
  logic sync_n = 1'b1;
  logic ts_n = 1'b1;
  logic sysref = 1'b0;
  logic tick = 1'b0;
  logic rst_n_o, pd_o, clk_en_o, start_o, scr_o, twos_o, alt_o, sreq_o, bnd_o;
  logic [7:0] fmt_o;
  logic [15:0] cnt_o;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int starts = 0;
  int bnds = 0;
  logic [7:0] d;
  logic [7:0] rst_vals [5] = '{8'h01, 8'h02, 8'h1f, 8'h01, 8'h03};

  always #4 i_sys_clk = ~i_sys_clk;

  slc_link_if link ();
  slc_host_end i_slc_host_end (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(sw_addr),
    .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd), .o_rdata(o_rdata), .o_cal_en(o_cal_en),
    .bus(link));
  slc_dev_end i_slc_dev_end (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .bus(link),
    .i_sync_pin_n(sync_n), .i_timestamp_pin_n(ts_n), .i_sysref(sysref), .i_frame_tick(tick),
    .i_format_limit(8'h20), .i_frame_octets_f(8'h08), .i_multiblocks_e(8'h02),
    .o_link_rst_n(rst_n_o), .o_serdes_pd(pd_o), .o_link_clk_en(clk_en_o),
    .o_link_start(start_o), .o_link_format(fmt_o), .o_scramble_en(scr_o), .o_twos_comp(twos_o),
    .o_alt_lanes(alt_o), .o_sync_request(sreq_o), .o_mf_boundary(bnd_o), .o_mf_count(cnt_o));
  slc_link_chk i_slc_link_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

  // One-cycle pulses are counted here so that no test has to hit the exact cycle.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (start_o === 1'b1) starts++;
    if (bnd_o === 1'b1) bnds++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    sw_addr  <= a;
    sw_wdata <= v;
    sw_wr    <= 1'b1;
    @(posedge i_sys_clk);
    sw_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge i_sys_clk);
    sw_rd <= 1'b0;
    @(negedge i_sys_clk);
    v = o_rdata;
  endtask : reg_rd

  task automatic settle();
    repeat (5) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask : settle

  task automatic bank_wr(input logic [2:0] idx, input logic [7:0] v);
    reg_wr(`SLC_H_SEL, {5'h00, idx});
    reg_wr(`SLC_H_DATA, v);
    reg_wr(`SLC_H_GO, 8'h01);
    settle();
  endtask : bank_wr

  task automatic bank_rd(input logic [2:0] idx, output logic [7:0] v);
    reg_wr(`SLC_H_SEL, {5'h00, idx});
    reg_wr(`SLC_H_GO, 8'h02);
    repeat (4) @(posedge i_sys_clk);
    reg_rd(`SLC_H_RDATA, v);
  endtask : bank_rd

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      tick <= 1'b1;
      @(posedge i_sys_clk);
      tick <= 1'b0;
    end
    settle();
  endtask : frames

  task automatic pulse_sysref();
    @(posedge i_sys_clk);
    sysref <= 1'b1;
    @(posedge i_sys_clk);
    sysref <= 1'b0;
    settle();
  endtask : pulse_sysref

  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    settle();
    for (int i = 0; i < 5; i++) begin
      bank_rd(3'(i), d);
      check(16'(d), 16'(rst_vals[i]));
    end
    check({rst_n_o, pd_o, clk_en_o, scr_o, twos_o, alt_o}, 16'h002e);
    check(16'(fmt_o), 16'h0002);
    // Turning the link off must stop it and hold the multiframe counter at zero.
    bank_wr(0, 8'h00);
    check({rst_n_o, pd_o, clk_en_o}, 16'h0002);
    pulse_sysref();
    frames(5);
    check(cnt_o, 16'h0000);
    bank_wr(1, 8'h30);
    bank_rd(1, d);
    check(16'(d), 16'h0002);
    bank_wr(1, 8'h05);
    bank_rd(1, d);
    check(16'(d), 16'h0005);
    check(16'(fmt_o), 16'h0005);
    bank_wr(2, 8'h03);
    bank_wr(4, 8'hf0);
    bank_rd(4, d);
    check(16'(d), 16'h00f0);
    check({scr_o, twos_o, alt_o}, 16'h0001);
    // Enabling without calibration is refused and flagged.
    bank_wr(0, 8'h01);
    reg_rd(`SLC_H_STAT, d);
    check(16'(d[`SLC_ST_REF]), 16'h0001);
    check(16'(rst_n_o), 16'h0000);
    reg_wr(`SLC_H_STAT, 8'h02);
    reg_wr(`SLC_H_CAL, 8'h01);
    starts = 0;
    bank_wr(0, 8'h01);
    check({rst_n_o, pd_o, clk_en_o}, 16'h0005);
    check(16'(starts), 16'h0001);
    reg_wr(`SLC_H_CAL, 8'h00);
    settle();
    check(16'(o_cal_en), 16'h0001);
    bank_wr(1, 8'h07);
    bank_rd(1, d);
    check(16'(d), 16'h0005);
    bnds = 0;
    frames(8);
    check(16'(bnds), 16'h0002);
    frames(2);
    check(cnt_o, 16'h0002);
    // While the link runs, a SYSREF edge realigns the counter.
    pulse_sysref();
    check(cnt_o, 16'h0000);
    // A 64b/66b format takes its frame count from E and F, here 64 frames.
    bank_wr(0, 8'h00);
    reg_wr(`SLC_H_CAL, 8'h00);
    bank_wr(1, 8'h10);
    reg_wr(`SLC_H_CAL, 8'h01);
    bank_wr(0, 8'h01);
    bnds = 0;
    frames(64);
    check(16'(bnds), 16'h0001);
    bank_wr(0, 8'h00);
    for (int s = 0; s < 3; s++) begin
      bank_wr(4, 8'(s << 2));
      for (int p = 0; p < 2; p++) begin
        @(posedge i_sys_clk);
        sync_n <= (p != 0);
        ts_n   <= (p != 1);
        settle();
        check(16'(sreq_o), 16'(s == p));
      end
    end
    @(posedge i_sys_clk);
    sync_n <= 1'b1;
    ts_n   <= 1'b1;
    settle();
    check(16'(sreq_o), 16'h0000);
    bank_wr(3, 8'h00);
    check(16'(sreq_o), 16'h0001);
    bank_wr(3, 8'h01);
    check(16'(sreq_o), 16'h0000);
    wrap_up();
  end
endmodule : tb_serial_link_control_regs
`default_nettype wire
